// *** hdl/prom_pkg.sv ***
// Constants shared by the configuration memory serial reader.
// Assumes a single 100 MHz system clock; the link clock arrives as a pin.
package prom_pkg;
    // Capacity in stored bits; kept small by default for simulation.
    localparam int unsigned CAPACITY_BITS = 1024;
    // Width of the combined address and bit counter.
    localparam int unsigned CNT_W = $clog2(CAPACITY_BITS) + 1;
    // Bits per parallel transfer.
    localparam int unsigned BYTE_W = 8;
    // Number of parallel words in the array.
    localparam int unsigned WORDS = CAPACITY_BITS / BYTE_W;
    // Last valid bit position (terminal count) in serial mode.
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CAPACITY_BITS - 1);
    // Last valid word position in parallel mode.
    localparam logic [CNT_W-1:0] LAST_WORD = CNT_W'(WORDS - 1);
    // Reset value of the counter.
    localparam logic [CNT_W-1:0] CNT_RST = '0;
    // Reset value of the synchronisers and of the cascade output.
    localparam logic SYNC_RST = 1'b0;
    localparam logic CASCADE_RST = 1'b1;
endpackage : prom_pkg

// *** hdl/config_prom_serial_reader.sv ***
// Read side of a one-time-programmable configuration memory.
// Assumes the loader drives config_clock, chip_enable_n and reset_oe as pins;
// they are sampled on clk through two flip-flops before use.
// Operation
// RULE_01: Loader picks master serial with straps low.
// RULE_02: Bits leave serially in address order.
// RULE_03: Every valid clock edge advances the counter.
// RULE_04: Link is data, two controls, one clock.
// RULE_05: After last bit, cascade low, data floats.
// RULE_06: Low chip select enables data, continuing stream.
// RULE_07: Low reload request clears counter when inverted.
// RULE_08: Deselected: standby, float, cascade high, hold.
// RULE_09: Reset polarity is a fixed setting.
// RULE_10: Serial or parallel output fixed setting.
// RULE_11: Use reset active-low with the loader.
// RULE_12: Increment and drive up to terminal count.
// RULE_13: Active reset holds counter, floats, cascade high.
// RULE_14: Parallel option gives one byte per clock.
// RULE_15: Busy high freezes data and counter; the code freezes them in parallel mode only.
// RULE_16: Loader drives reset from its init status.
// RULE_17: Counter indexes every bit; terminal at last.
module config_prom_serial_reader (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       config_clock,
    input  wire logic                       chip_enable_n,
    input  wire logic                       reset_oe,
    input  wire logic                       busy,
    input  wire logic                       reset_active_high,
    input  wire logic                       parallel_mode,
    input  wire logic                       prog_we,
    input  wire logic [prom_pkg::CNT_W-1:0] prog_addr,
    input  wire logic [prom_pkg::BYTE_W-1:0] prog_data,
    output logic      [prom_pkg::BYTE_W-1:0] data_out,
    output logic      [prom_pkg::BYTE_W-1:0] data_oe,
    output logic                            cascade_out_n,
    output logic                            standby,
    output logic      [prom_pkg::CNT_W-1:0] address_q
);
    // Stored bitstream, one byte per word; bit 0 of word 0 goes first.
    logic [prom_pkg::BYTE_W-1:0] mem [prom_pkg::WORDS];

    // Two-stage synchronisers for the pins; stage one feeds only stage two.
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       busy1_q;
    logic       busy2_q;
    logic       clk_prev_q;  // Previous synchronised link clock level.

    // Settings latched once after reset; they stand for nonvolatile fuses.
    logic pol_high_q;
    logic par_q;
    logic fixed_q;    // Settings have been caught since the last reset.

    logic rise;       // One-cycle pulse on a rising link clock edge.
    logic rst_act;    // Reset/output-enable pin at its active level.
    logic sel;        // Chip selected.
    logic at_end;     // Counter past the terminal count.
    logic [prom_pkg::CNT_W-1:0] last;  // Terminal count for this mode.

    // Word of the array that a counter value points into. In serial mode
    // the counter indexes bits, so the low three bits pick the bit within
    // the word; in parallel mode the counter indexes whole words. Both the
    // programming port and the read path use this, so the two can never
    // disagree about where a byte lives.
    function automatic logic [prom_pkg::CNT_W-5:0] word_index(
        input logic [prom_pkg::CNT_W-1:0] addr,
        input logic                       by_word
    );
        if (by_word) begin
            return addr[prom_pkg::CNT_W-5:0];
        end else begin
            return addr[prom_pkg::CNT_W-2:3];
        end
    endfunction : word_index

    // Write port that fills the array, standing in for the programmer.
    always_ff @(posedge clk) begin
        if (prog_we) begin
            // The programming port always addresses whole words.
            mem[word_index(prog_addr, 1'b1)] <= prog_data;
        end
    end

    // Pins cross into clk; the loader's clock is much slower than clk.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q    <= {3{prom_pkg::SYNC_RST}};
            sync2_q    <= {3{prom_pkg::SYNC_RST}};
            busy1_q    <= prom_pkg::SYNC_RST;
            busy2_q    <= prom_pkg::SYNC_RST;
            clk_prev_q <= prom_pkg::SYNC_RST;
        end else begin
            sync1_q    <= {config_clock, chip_enable_n, reset_oe}; // see RULE_04
            sync2_q    <= sync1_q;
            busy1_q    <= busy;
            busy2_q    <= busy1_q;
            clk_prev_q <= sync2_q[2];
        end
    end

    // Fixed settings are caught once after release of reset, while the
    // link is idle, and never change after, as a one-time-programmed
    // option would behave. Toggling the setting ports later has no effect
    // until the next reset, which stands for power-up.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pol_high_q <= 1'b0;
            par_q      <= 1'b0;
            fixed_q    <= 1'b0;
        end else if (!fixed_q && !sync2_q[0] && !sync2_q[1] &&
                     address_q == '0 && clk_prev_q == 1'b0 && !rise) begin
            pol_high_q <= reset_active_high;  // see RULE_09 see RULE_11
            par_q      <= parallel_mode;      // see RULE_10
            fixed_q    <= 1'b1;
        end
    end

    assign rise    = sync2_q[2] & ~clk_prev_q;                  // see RULE_03
    assign rst_act = pol_high_q ? sync2_q[0] : ~sync2_q[0];     // see RULE_07
    assign sel     = ~sync2_q[1];                               // see RULE_06
    assign last    = par_q ? prom_pkg::LAST_WORD : prom_pkg::LAST_BIT;
    assign at_end  = address_q > last;                          // see RULE_17

    // Address and bit counter: reset wins, then select, then terminal count.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            address_q <= prom_pkg::CNT_RST;
        end else if (rst_act) begin
            address_q <= prom_pkg::CNT_RST;                     // see RULE_13
        end else if (sel && rise && !at_end &&
                     !(par_q && busy2_q)) begin
            address_q <= address_q + 1'b1;            // see RULE_12 see RULE_15
        end
    end

    // Output stage updates on the rising edge, like the memory's access time.
    // A frozen edge under busy leaves the presented data untouched.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out      <= '0;
            data_oe       <= '0;
            cascade_out_n <= prom_pkg::CASCADE_RST;
            standby       <= 1'b0;
        end else begin
            standby <= ~sel;                                    // see RULE_08
            if (rst_act || !sel) begin
                data_oe       <= '0;                 // see RULE_08 see RULE_13
                cascade_out_n <= 1'b1;
            end else if (at_end) begin
                data_oe       <= '0;                            // see RULE_05
                cascade_out_n <= 1'b0;
            end else begin
                cascade_out_n <= 1'b1;
                if (par_q) begin
                    data_oe <= '1;                              // see RULE_14
                    if (!busy2_q) begin
                        data_out <= mem[word_index(address_q, 1'b1)];
                    end
                end else begin
                    data_oe  <= {{(prom_pkg::BYTE_W-1){1'b0}}, 1'b1};
                    data_out <= {{(prom_pkg::BYTE_W-1){1'b0}},
                                 mem[word_index(address_q, 1'b0)]
                                    [address_q[2:0]]};          // see RULE_02
                end
            end
        end
    end

    // The assertions below look at the outputs one clk after the cause,
    // since every output is registered. All of them live in the clk
    // domain and are off while resetn is low; the first edges after
    // release still see the synchroniser reset values, which read as an
    // active reset for the active-low default polarity.

    // Reset holds the counter at zero one cycle later.
    AST_RESET_HOLDS: assert property (                          // see RULE_13
        @(posedge clk) disable iff (!resetn)
        rst_act |=> address_q == '0)
        else $error("Counter not held at zero under reset.");

    // Floating under reset or deselect.
    AST_FLOAT: assert property (                                // see RULE_08
        @(posedge clk) disable iff (!resetn)
        (rst_act || !sel) |=> data_oe == '0 && cascade_out_n)
        else $error("Data driven or cascade low while idle.");

    // Past terminal count the cascade goes low and data floats.
    AST_CASCADE: assert property (                              // see RULE_05
        @(posedge clk) disable iff (!resetn)
        (!rst_act && sel && at_end) |=> !cascade_out_n && data_oe == '0)
        else $error("Terminal count did not hand off.");

    // Deselect holds the address.
    AST_HOLD: assert property (                                 // see RULE_08
        @(posedge clk) disable iff (!resetn)
        (!rst_act && !sel) |=> address_q == $past(address_q))
        else $error("Address moved while deselected.");

    // A valid edge advances by one.
    AST_ADVANCE: assert property (                              // see RULE_03
        @(posedge clk) disable iff (!resetn)
        (!rst_act && sel && rise && !at_end && !(par_q && busy2_q))
        |=> address_q == $past(address_q) + 1'b1)
        else $error("Counter did not advance on a valid edge.");

    // Busy in parallel mode freezes the counter.
    AST_BUSY: assert property (                                 // see RULE_15
        @(posedge clk) disable iff (!resetn)
        (!rst_act && par_q && busy2_q) |=> $stable(address_q))
        else $error("Counter moved while busy.");

    // Counter never passes one beyond the serial terminal count, LAST_BIT.
    AST_BOUND: assert property (                                // see RULE_17
        @(posedge clk) disable iff (!resetn)
        address_q <= prom_pkg::LAST_BIT + 1'b1)
        else $error("Counter ran past terminal count.");

    // Serial mode drives only the lowest data line.
    AST_SERIAL: assert property (                               // see RULE_02
        @(posedge clk) disable iff (!resetn)
        (!par_q && !rst_act && sel && !at_end) |=> data_oe == 8'h01)
        else $error("Serial mode drove more than one line.");

    // A deselected memory reports standby on the next cycle, so that the
    // loader's supply budget can rely on the flag.
    AST_STANDBY_ON: assert property (                           // see RULE_08
        @(posedge clk) disable iff (!resetn)
        !sel |=> standby)
        else $error("Standby missing while deselected.");

    // A selected memory leaves standby so that it can stream; a stuck
    // standby would hide the continuation of a cascaded chain.
    AST_STANDBY_OFF: assert property (                          // see RULE_06
        @(posedge clk) disable iff (!resetn)
        sel |=> !standby)
        else $error("Standby stayed on while selected.");

    // Reset wins over select: cascade stays high and data floats even
    // when the chip is selected.
    AST_RESET_CASCADE: assert property (                        // see RULE_13
        @(posedge clk) disable iff (!resetn)
        rst_act |=> cascade_out_n && data_oe == '0)
        else $error("Reset did not float data or raise cascade.");

    // Inside the stored range a selected memory drives data and keeps
    // the cascade output high, so the next memory stays quiet.
    AST_DRIVE: assert property (                                // see RULE_12
        @(posedge clk) disable iff (!resetn)
        (!rst_act && sel && !at_end) |=> cascade_out_n && data_oe != '0)
        else $error("Data not driven inside the stored range.");

    // Beyond the terminal count the address is held, whatever the link
    // clock does, until reset clears it.
    AST_END_HOLD: assert property (                             // see RULE_12
        @(posedge clk) disable iff (!resetn)
        (!rst_act && at_end) |=> address_q == $past(address_q))
        else $error("Address moved beyond terminal count.");

    // The parallel option drives every data line while streaming.
    AST_PAR_OE: assert property (                               // see RULE_14
        @(posedge clk) disable iff (!resetn)
        (par_q && !rst_act && sel && !at_end) |=> data_oe == 8'hff)
        else $error("Parallel mode did not drive a full byte.");

    // Busy in parallel mode freezes the presented byte as well as the counter, so the
    // loader may stall without losing a word.
    AST_BUSY_DATA: assert property (                            // see RULE_15
        @(posedge clk) disable iff (!resetn)
        (par_q && busy2_q && !rst_act && sel && !at_end)
        |=> $stable(data_out))
        else $error("Data changed while busy.");

    // Out of reset the counter only holds or steps by one: no bit is
    // ever skipped, even if two link edges come close together.
    AST_NO_SKIP: assert property (                              // see RULE_03
        @(posedge clk) disable iff (!resetn)
        !rst_act |=> address_q == $past(address_q) ||
                     address_q == $past(address_q) + 1'b1)
        else $error("Counter skipped a position.");

    // Once caught, the settings behave like fuses and do not move.
    AST_SETTINGS_FIXED: assert property (          // see RULE_09 see RULE_10
        @(posedge clk) disable iff (!resetn)
        fixed_q |=> $stable(pol_high_q) && $stable(par_q))
        else $error("Fixed setting changed after it was caught.");

    // A low cascade output can only follow a selected memory that has
    // run past its terminal count with reset inactive.
    AST_CASCADE_CAUSE: assert property (                        // see RULE_05
        @(posedge clk) disable iff (!resetn)
        !cascade_out_n |-> $past(at_end) && $past(sel) && !$past(rst_act))
        else $error("Cascade went low without terminal count.");

    // With the inverted polarity a low reload request clears the count.
    AST_RELOAD: assert property (                               // see RULE_07
        @(posedge clk) disable iff (!resetn)
        (!pol_high_q && !sync2_q[0]) |=> address_q == '0)
        else $error("Low reload request did not clear the counter.");

    // Enables only ever take the idle, serial or parallel shape.
    AST_OE_SHAPE: assert property (                             // see RULE_02
        @(posedge clk) disable iff (!resetn)
        data_oe == '0 || data_oe == 8'h01 || data_oe == 8'hff)
        else $error("Data enables in an illegal pattern.");

    // In serial mode the unused data lines carry zero.
    AST_SERIAL_ONE: assert property (                           // see RULE_02
        @(posedge clk) disable iff (!resetn)
        !par_q |-> data_out[prom_pkg::BYTE_W-1:1] == '0)
        else $error("Serial mode put data on an unused line.");
endmodule : config_prom_serial_reader

// *** verif/loader_model.sv ***
// Behavioural loader that drives the link pins of the memory.
// Assumes the bench calls its tasks and clk is the 100 MHz clock.
module loader_model (
    input  wire logic clk,
    output logic      config_clock,
    output logic      chip_enable_n,
    output logic      reset_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // Master serial is picked only with all straps low.
    localparam logic [2:0] MODE_STRAPS = 3'h0;
    // The link clock stands still low outside frames.
    initial begin
        config_clock  = 1'b0;
        chip_enable_n = 1'b1;
        reset_oe      = 1'b0;
    end
    // One link period: one system clock of wait, four system clocks high and four low.
    task automatic pulse();
        @(negedge clk);
        config_clock = (MODE_STRAPS == 3'h0);
        repeat (4) @(negedge clk);
        config_clock = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pulse
    // Reset stays active low, driven like an init status line.
    task automatic set_ctl(input logic ce_n, input logic rst_n);
        @(negedge clk);
        chip_enable_n = ce_n;
        reset_oe      = rst_n;
        repeat (6) @(negedge clk);
    endtask : set_ctl
endmodule : loader_model

// *** verif/tb_top.sv ***
// Self-checking bench for the configuration memory serial reader.
// Assumes default prom_pkg sizes and the loader model on the link.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        clk, resetn, prog_we, cfg_clk, ce_n;
    logic                        rst_oe, cascade_out_n, standby;
    logic                        par_mode, busy_in;
    logic [prom_pkg::CNT_W-1:0]  prog_addr, address_q;
    logic [prom_pkg::BYTE_W-1:0] prog_data, data_out, data_oe;
    int                          n_errors = 0;
    int                          samples_checked = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    loader_model ldr (.clk(clk), .config_clock(cfg_clk),
        .chip_enable_n(ce_n), .reset_oe(rst_oe));
    config_prom_serial_reader dut (.clk(clk), .resetn(resetn),
        .config_clock(cfg_clk), .chip_enable_n(ce_n), .reset_oe(rst_oe),
        .busy(busy_in), .reset_active_high(1'b0), .parallel_mode(par_mode),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_out(data_out), .data_oe(data_oe), .cascade_out_n(cascade_out_n),
        .standby(standby), .address_q(address_q));
    // Compares one value; case inequality lets no unknown pass.
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Outputs of a memory that is not streaming.
    task automatic chk_quiet(input int a, input logic sb);
        chk("address_q", 16'(a), 16'(address_q));
        chk("data_oe", 16'h0, 16'(data_oe));
        chk("cascade_out_n", 16'h1, 16'(cascade_out_n));
        chk("standby", 16'(sb), 16'(standby));
    endtask : chk_quiet
    // Stored byte pattern; serial bit k is byte k/8, bit k%8.
    function automatic logic exp_bit(input int k);
        logic [7:0] b;
        b = 8'(k / 8) ^ 8'ha5;
        return b[k % 8];
    endfunction : exp_bit
    // Reset, fill the array, then stream every bit with hazards mixed in.
    initial begin
        resetn = 1'b0;
        prog_we = 1'b0;
        prog_addr = '0;
        prog_data = '0;
        par_mode = 1'b0;
        busy_in = 1'b0;
        repeat (3) @(negedge clk);
        chk_quiet(0, 1'b0);
        resetn = 1'b1;
        for (int w = 0; w < prom_pkg::WORDS; w++) begin
            @(negedge clk);
            prog_we = 1'b1;
            prog_addr = prom_pkg::CNT_W'(w);
            prog_data = 8'(w) ^ 8'ha5;
        end
        @(negedge clk);
        prog_we = 1'b0;
        ldr.set_ctl(1'b0, 1'b0);
        repeat (3) ldr.pulse();
        chk_quiet(0, 1'b0);
        ldr.set_ctl(1'b0, 1'b1);
        for (int k = 0; k < prom_pkg::CAPACITY_BITS; k++) begin
            if (k == 5) begin
                ldr.set_ctl(1'b1, 1'b1);
                repeat (2) ldr.pulse();
                chk_quiet(5, 1'b1);
                ldr.set_ctl(1'b0, 1'b1);
            end
            chk("address_q", 16'(k), 16'(address_q));
            chk("data bit", 16'(exp_bit(k)), 16'(data_out[0]));
            chk("data_oe bit", 16'h1, 16'(data_oe[0]));
            chk("cascade_out_n", 16'h1, 16'(cascade_out_n));
            ldr.pulse();
        end
        repeat (2) ldr.pulse();
        chk("address_q", 16'(prom_pkg::CAPACITY_BITS), 16'(address_q));
        chk("data_oe", 16'h0, 16'(data_oe));
        chk("cascade_out_n", 16'h0, 16'(cascade_out_n));
        ldr.set_ctl(1'b0, 1'b0);
        chk_quiet(0, 1'b0);
        ldr.set_ctl(1'b0, 1'b1);
        chk("data bit", 16'(exp_bit(0)), 16'(data_out[0]));
        run_parallel();
        give_verdict();
    end
    // Second power-up in byte mode: words stream whole, busy freezes them.
    task automatic run_parallel();
        logic [7:0] wd;
        @(negedge clk);
        resetn = 1'b0;
        par_mode = 1'b1;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        for (int w = 0; w < prom_pkg::WORDS; w++) begin
            wd = 8'(w) ^ 8'ha5;
            if (w == 3) begin
                busy_in = 1'b1;
                @(negedge clk);
                repeat (2) ldr.pulse();
                chk("address_q", 16'(w), 16'(address_q));
                chk("data_out", 16'(wd), 16'(data_out));
                busy_in = 1'b0;
                @(negedge clk);
            end
            chk("address_q", 16'(w), 16'(address_q));
            chk("data_out", 16'(wd), 16'(data_out));
            chk("data_oe", 16'h00ff, 16'(data_oe));
            ldr.pulse();
        end
        chk("address_q", 16'(prom_pkg::WORDS), 16'(address_q));
        chk("cascade_out_n", 16'h0, 16'(cascade_out_n));
    endtask : run_parallel
    // Cuts a hang short and reports it as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
endmodule : tb_top
